// File: src/lane_mask_write.sv
// write port with per-beat lane masking and an avalon view of the array
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "lane_mask_defines.svh"
module lane_mask_write (
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RST,
  input  wire logic                   I_WRITE_PORT_SELECT_N,
  input  wire logic [`LM_BASE_W-1:0]  I_WRITE_ADDR,
  input  wire lane_mask_pkg::beat_t   I_BEAT_RISE,
  input  wire lane_mask_pkg::beat_t   I_BEAT_FALL,
  input  wire logic [`LM_ADDR_W-1:0]  I_AVS_ADDRESS,
  input  wire logic                   I_AVS_READ,
  input  wire logic                   I_AVS_WRITE,
  input  wire logic [31:0]            I_AVS_WRITEDATA,
  output logic [31:0]                 O_AVS_READDATA,
  output logic                        O_AVS_WAITREQUEST
);
  // ========================================================
  // lane merge: low select takes new lane, high keeps old
  function automatic logic [`LM_WORD_W-1:0] lane_merge(
    input logic [`LM_WORD_W-1:0] old_w,
    input logic [`LM_WORD_W-1:0] new_w,
    input logic [`LM_LANES-1:0]  sel_n);
    logic [`LM_WORD_W-1:0] res;
    res = old_w;
    for (int i = 0; i < `LM_LANES; i++) begin
      if (!sel_n[i]) begin
        res[i*`LM_LANE_W +: `LM_LANE_W] =
          new_w[i*`LM_LANE_W +: `LM_LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  // ========================================================
  // state
  logic [`LM_WORD_W-1:0]  mem [`LM_WORDS];
  lane_mask_pkg::burst_st_t st_q;
  logic                   req_prev_q;
  logic [`LM_BASE_W-1:0]  base_q;
  logic                   en_q;
  logic [7:0]             bursts_q;
  logic [7:0]             ignored_q;
  logic [`LM_IDX_W-1:0]   rdaddr_q;
  logic                   wait_q;
  logic [31:0]            rdata_q;
  logic                   req_raw;
  logic                   req_ok;
  logic                   beating;
  logic [`LM_IDX_W-1:0]   idx_r;
  logic [`LM_IDX_W-1:0]   idx_f;
  logic [`LM_WORD_W-1:0]  old_r;
  logic [`LM_WORD_W-1:0]  old_f;
  logic                   bus_req;
  logic                   bus_done;

  // request qualification
  assign req_raw = !I_WRITE_PORT_SELECT_N && en_q;
  assign req_ok  = req_raw && !req_prev_q;
  assign beating = (st_q == lane_mask_pkg::ST_B01) ||
                   (st_q == lane_mask_pkg::ST_B23);
  // word index of each beat inside the burst
  assign idx_r = {base_q, (st_q == lane_mask_pkg::ST_B23), 1'b0};
  assign idx_f = {base_q, (st_q == lane_mask_pkg::ST_B23), 1'b1};
  assign old_r = mem[idx_r];
  assign old_f = mem[idx_f];

  // ========================================================
  // burst sequencer
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      st_q <= lane_mask_pkg::ST_IDLE;
    end else begin
      case (st_q)
        lane_mask_pkg::ST_IDLE: begin
          if (req_ok) begin
            st_q <= lane_mask_pkg::ST_B01;
          end
        end
        lane_mask_pkg::ST_B01: begin
          st_q <= lane_mask_pkg::ST_B23;
        end
        lane_mask_pkg::ST_B23: begin
          st_q <= req_ok ? lane_mask_pkg::ST_B01 : lane_mask_pkg::ST_IDLE;
        end
        default: begin
          st_q <= lane_mask_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // previous-edge request and burst base address
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      req_prev_q <= 1'b0;
      base_q     <= '0;
    end else begin
      req_prev_q <= req_raw;
      if (req_ok) begin
        base_q <= I_WRITE_ADDR;
      end
    end
  end

  // ========================================================
  // array: both beats of a cycle, each with its own mask
  // the true and complementary halves arrive as two beat inputs
  // sampled on one edge; each beat merges into its own word, so
  // the two masks never interact
  always_ff @(posedge I_MCLK) begin
    if (beating) begin
      mem[idx_r] <= lane_merge(old_r, I_BEAT_RISE.data,
                               I_BEAT_RISE.sel);
      mem[idx_f] <= lane_merge(old_f, I_BEAT_FALL.data,
                               I_BEAT_FALL.sel);
    end
  end

  // ========================================================
  // counters of accepted and dropped requests
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      bursts_q  <= 8'h00;
      ignored_q <= 8'h00;
    end else begin
      if (req_ok) begin
        bursts_q <= bursts_q + 8'h01;
      end
      if (req_raw && req_prev_q) begin
        ignored_q <= ignored_q + 8'h01;
      end
    end
  end

  // ========================================================
  // avalon slave: one wait cycle, then the answer
  // waitrequest idles high, so every request waits exactly once
  assign bus_req  = I_AVS_READ || I_AVS_WRITE;
  assign bus_done = bus_req && !wait_q;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(bus_req && wait_q);
    end
  end

  // software-written registers
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      en_q     <= `LM_CTRL_RST;
      rdaddr_q <= '0;
    end else if (bus_done && I_AVS_WRITE) begin
      case (I_AVS_ADDRESS)
        `LM_REG_CTRL: begin
          en_q <= I_AVS_WRITEDATA[`LM_CTRL_EN_BIT];
        end
        `LM_REG_RDADDR: begin
          rdaddr_q <= I_AVS_WRITEDATA[`LM_IDX_W-1:0];
        end
        default: begin
          en_q <= en_q;
        end
      endcase
    end
  end

  // read data, loaded as the wait cycle ends
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rdata_q <= 32'h0;
    end else if (bus_req && wait_q && I_AVS_READ) begin
      case (I_AVS_ADDRESS)
        `LM_REG_CTRL:   rdata_q <= {31'h0, en_q};
        `LM_REG_STATUS: rdata_q <= {13'h0, st_q, ignored_q, bursts_q};
        `LM_REG_RDADDR: rdata_q <= {26'h0, rdaddr_q};
        `LM_REG_RDDATA: rdata_q <= mem[rdaddr_q][31:0];
        default:        rdata_q <= 32'h0;
      endcase
    end
  end

  assign O_AVS_READDATA    = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;

  // ========================================================
  // checks on the write path
  chk_all_lanes_write: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'h0 |=>
      mem[$past(idx_r)] == $past(I_BEAT_RISE.data))
    else $error("full word not stored");

  chk_lane_zero_only: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'hE |=>
      mem[$past(idx_r)] == {$past(old_r[35:9]),
                            $past(I_BEAT_RISE.data[8:0])})
    else $error("lane zero write wrong");

  chk_lane_one_only: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'hD |=>
      mem[$past(idx_r)] == {$past(old_r[35:18]),
        $past(I_BEAT_RISE.data[17:9]), $past(old_r[8:0])})
    else $error("lane one write wrong");

  chk_lane_two_only: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'hB |=>
      mem[$past(idx_r)] == {$past(old_r[35:27]),
        $past(I_BEAT_RISE.data[26:18]), $past(old_r[17:0])})
    else $error("lane two write wrong");

  chk_lane_three_only: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'h7 |=>
      mem[$past(idx_r)] == {$past(I_BEAT_RISE.data[35:27]),
                            $past(old_r[26:0])})
    else $error("lane three write wrong");

  chk_no_lane_hold: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'hF |=>
      mem[$past(idx_f)] == $past(old_f))
    else $error("masked beat modified word");

  chk_fall_beat_full: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'h0 |=>
      mem[$past(idx_f)] == $past(I_BEAT_FALL.data))
    else $error("falling beat not stored");

  chk_burst_order: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    req_ok |=> st_q == lane_mask_pkg::ST_B01 && base_q == $past(I_WRITE_ADDR)
      ##1 st_q == lane_mask_pkg::ST_B23 && idx_r[1:0] == 2'h2)
    else $error("burst beats out of order");

  chk_back_to_back: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    req_ok ##1 !I_WRITE_PORT_SELECT_N |=>
      st_q == lane_mask_pkg::ST_B23 && $stable(base_q))
    else $error("second request not ignored");

  chk_lane_mix: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'hA |=>
      mem[$past(idx_r)] == {$past(old_r[35:27]),
        $past(I_BEAT_RISE.data[26:18]), $past(old_r[17:9]),
        $past(I_BEAT_RISE.data[8:0])})
    else $error("mixed lane write wrong");

  // ========================================================
  // checks on the complementary-half beat, one per lane code, and the all-high hold of the true-half beat
  chk_fall_lane_zero: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'hE |=>
      mem[$past(idx_f)] == {$past(old_f[35:9]),
                            $past(I_BEAT_FALL.data[8:0])})
    else $error("fall lane zero write wrong");

  chk_fall_lane_one: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'hD |=>
      mem[$past(idx_f)] == {$past(old_f[35:18]),
        $past(I_BEAT_FALL.data[17:9]), $past(old_f[8:0])})
    else $error("fall lane one write wrong");

  chk_fall_lane_two: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'hB |=>
      mem[$past(idx_f)] == {$past(old_f[35:27]),
        $past(I_BEAT_FALL.data[26:18]), $past(old_f[17:0])})
    else $error("fall lane two write wrong");

  chk_fall_lane_three: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'h7 |=>
      mem[$past(idx_f)] == {$past(I_BEAT_FALL.data[35:27]),
                            $past(old_f[26:0])})
    else $error("fall lane three write wrong");

  chk_rise_lane_hold: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_RISE.sel == 4'hF |=>
      mem[$past(idx_r)] == $past(old_r))
    else $error("masked rise beat modified word");

  chk_fall_lane_mix: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    beating && I_BEAT_FALL.sel == 4'h5 |=>
      mem[$past(idx_f)] == {$past(I_BEAT_FALL.data[35:27]),
        $past(old_f[26:18]), $past(I_BEAT_FALL.data[17:9]),
        $past(old_f[8:0])})
    else $error("fall mixed lane write wrong");

  // ========================================================
  // sequencer, dropped requests and bus timing
  chk_seq_one_hot: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    $onehot(st_q))
    else $error("sequencer state not one-hot");

  chk_ignore_keeps_base: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    req_raw && req_prev_q |=> $stable(base_q) && bursts_q == $past(bursts_q))
    else $error("ignored request changed the burst");

  chk_bus_one_wait: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    bus_req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");

  chk_bus_short_answer: assert property (@(posedge I_MCLK)
    disable iff (I_RST)
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
endmodule : lane_mask_write

// File: src/lane_mask_defines.svh
// constants for the byte-lane write masking block
// Function
// - all four selects low: the whole 36-bit word is stored
// - only select zero low: bits 8..0 stored, rest kept
// - only select one low: bits 17..9 stored, rest kept
// - only select two low: bits 26..18 stored, rest kept
// - only select three low: bits 35..27 stored, rest kept
// - all four selects high: the location is left untouched
// - selects are taken with every beat, rising and falling half
// - four-word burst: words A, A+1 in one cycle, A+2, A+3 the next cycle
// - request on the cycle after a request is ignored
`ifndef LANE_MASK_DEFINES_SVH
`define LANE_MASK_DEFINES_SVH
// ==========================================================
// array and lane geometry
`define LM_WORD_W      36
`define LM_LANE_W      9
`define LM_LANES       4
`define LM_BASE_W      4
`define LM_WORDS       64
`define LM_IDX_W       6
// ==========================================================
// register map, byte addresses
`define LM_ADDR_W      4
`define LM_REG_CTRL    4'h0
`define LM_REG_STATUS  4'h4
`define LM_REG_RDADDR  4'h8
`define LM_REG_RDDATA  4'hC
`define LM_CTRL_EN_BIT 0
`define LM_CTRL_RST    1'h1
`endif

// File: src/lane_mask_pkg.sv
// types for the byte-lane write masking block
package lane_mask_pkg;
  // ========================================================
  // lane selects of one beat, active low
  typedef struct packed {
    logic lane3_write_select_n;
    logic lane2_write_select_n;
    logic lane1_write_select_n;
    logic lane0_write_select_n;
  } lane_sel_t;
  // one write-data beat
  typedef struct packed {
    lane_sel_t   sel;
    logic [35:0] data;
  } beat_t;
  // burst sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_B01  = 3'b010,
    ST_B23  = 3'b100
  } burst_st_t;
endpackage : lane_mask_pkg

// File: bench/lane_mask_ctrl_model.sv
// controller model that drives write bursts into the masking block
`timescale 1ns/1ps
module lane_mask_ctrl_model (
  input  wire logic            i_clk,
  output logic                 o_sel_n,
  output logic [3:0]           o_base,
  output lane_mask_pkg::beat_t o_rise,
  output lane_mask_pkg::beat_t o_fall
);
  // idle until the first burst
  initial begin
    o_sel_n = 1'b1;
    o_base  = 4'h0;
    o_rise  = '0;
    o_fall  = '0;
  end
  // ==========================================================
  // burst: request edge, then two beat cycles; dbl repeats the request
  task automatic burst(input logic [3:0] base, input logic dbl,
                       input lane_mask_pkg::beat_t [3:0] b);
    @(posedge i_clk);
    o_sel_n <= 1'b0;
    o_base  <= base;
    @(posedge i_clk);
    o_sel_n <= ~dbl;
    o_rise  <= b[0];
    o_fall  <= b[1];
    @(posedge i_clk);
    o_sel_n <= 1'b1;
    o_rise  <= b[2];
    o_fall  <= b[3];
    @(posedge i_clk);
    o_rise  <= ~b[2]; // released lines show the inverse
    o_fall  <= ~b[3];
    o_base  <= ~base;
  endtask : burst
endmodule : lane_mask_ctrl_model

// File: bench/lane_mask_write_tb_top.sv
// self-checking bench for the lane masking write port
`timescale 1ns/1ps
`include "lane_mask_defines.svh"
module lane_mask_write_tb_top;
  logic                        mclk = 1'b0;
  logic                        rst = 1'b1;
  logic                        wsel_n;
  logic [3:0]                  waddr;
  lane_mask_pkg::beat_t        rise;
  lane_mask_pkg::beat_t        fall;
  logic [`LM_ADDR_W-1:0]       av_addr = '0;
  logic                        av_read = 1'b0;
  logic                        av_write = 1'b0;
  logic [31:0]                 av_wdata = '0;
  logic [31:0]                 av_rdata;
  logic                        av_wait;
  logic [31:0]                 rd;
  logic [35:0]                 exp_mem [64];
  lane_mask_pkg::beat_t [3:0]  bt;
  int                          errors = 0;
  int                          cmp_count = 0;
  // ==========================================================
  // clock, design and controller model
  always #50 mclk = ~mclk;
  lane_mask_write u_lane_mask_write (
    .I_MCLK(mclk), .I_RST(rst), .I_WRITE_PORT_SELECT_N(wsel_n),
    .I_WRITE_ADDR(waddr), .I_BEAT_RISE(rise), .I_BEAT_FALL(fall),
    .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_read),
    .I_AVS_WRITE(av_write), .I_AVS_WRITEDATA(av_wdata),
    .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait));
  lane_mask_ctrl_model u_lane_mask_ctrl_model (
    .i_clk(mclk), .o_sel_n(wsel_n), .o_base(waddr),
    .o_rise(rise), .o_fall(fall));
  // ==========================================================
  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // compare one 32-bit value
  task automatic check32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %0s expected %h seen %h", nm, e, g);
    end
  endtask : check32
  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    av_addr  <= a;
    av_wdata <= d;
    av_read  <= ~w;
    av_write <= w;
    // read right after the edge, outputs still show what it sampled
    do begin
      @(posedge mclk);
      n++;
    end while (av_wait !== 1'b0 && n < 20);
    if (av_wait !== 1'b0) begin
      errors++;
      $display("Error waitrequest expected 0 seen %b", av_wait);
      finish_test();
    end
    q = av_rdata;
    av_read  <= 1'b0;
    av_write <= 1'b0;
  endtask : av
  // burst with per-beat selects, expected array update, read-back
  task automatic run(input logic [3:0] base, input logic dbl,
                     input logic en, input logic [3:0] s,
                     input logic [15:0] sels);
    for (int k = 0; k < 4; k++) begin
      bt[k].sel  = sels[4*k+:4];
      bt[k].data = 36'h9_C3A5_F00F ^ {9{base ^ k[3:0] ^ s}};
      for (int i = 0; i < 4; i++) begin
        if (en && !bt[k].sel[i]) begin
          exp_mem[{base, k[1:0]}][9*i+:9] = bt[k].data[9*i+:9];
        end
      end
    end
    u_lane_mask_ctrl_model.burst(base, dbl, bt);
    for (int k = 0; k < 4; k++) begin
      av(1'b1, `LM_REG_RDADDR, {26'h0, base, k[1:0]}, rd);
      av(1'b0, `LM_REG_RDDATA, 32'h0, rd);
      check32("word", exp_mem[{base, k[1:0]}][31:0], rd);
    end
    $display("burst at base %0d checked", base);
  endtask : run
  // ==========================================================
  // test sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    av(1'b0, `LM_REG_CTRL, 32'h0, rd);
    check32("ctrl", 32'h0000_0001, rd);
    av(1'b0, `LM_REG_STATUS, 32'h0, rd);
    check32("status", 32'h0001_0000, rd);
    av(1'b0, 4'h1, 32'h0, rd);
    check32("unmapped", 32'h0000_0000, rd);
    $display("reset values checked");
    run(4'h1, 1'b0, 1'b1, 4'h0, 16'h0000);
    run(4'h1, 1'b0, 1'b1, 4'h5, 16'h7BDE);
    run(4'h1, 1'b0, 1'b1, 4'h3, 16'hFA5F);
    run(4'h1, 1'b0, 1'b1, 4'h6, 16'hE7BD);
    run(4'h2, 1'b1, 1'b1, 4'h0, 16'h0000);
    av(1'b0, `LM_REG_STATUS, 32'h0, rd);
    check32("status", 32'h0001_0105, rd);
    av(1'b1, `LM_REG_CTRL, 32'h0, rd);
    run(4'h1, 1'b0, 1'b0, 4'h9, 16'h0000);
    av(1'b1, `LM_REG_CTRL, 32'h1, rd);
    finish_test();
  end
endmodule : lane_mask_write_tb_top
